// ### hw/spi_port_pkg.sv
package spi_port_pkg;

  localparam int addr_bits = 7;
  localparam int data_bits = 16;
  // address bits plus the read/write indicator
  localparam int head_bits = addr_bits + 1;
  localparam logic [4:0] head_last = 5'h07;
  localparam logic [4:0] data_count_max = 5'h10;
  localparam logic read_flag = 1'b1;
  localparam logic [2:0] sync_reset = 3'h0;
  localparam logic [15:0] data_reset = 16'h0000;

  typedef struct packed {
    logic [6:0] addr;
    logic [15:0] data;
  } reg_access_type;

  typedef enum logic [1:0] {
    st_idle,
    st_head,
    st_write,
    st_read
  } frame_state_type;

endpackage

// ### hw/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module pin_sync (
  input wire logic clk,
  input wire logic resetn,
  input wire logic pin,
  output logic synced
);

  logic meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_r <= 1'b0;
      synced <= 1'b0;
    end
    else
    begin
      meta_r <= pin;
      synced <= meta_r;
    end
  end

endmodule

`default_nettype wire

// ### hw/three_wire_register_port.sv
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - sample the data line on each rising serial clock edge
// - data line is input, or driven by the block during read data
// - a frame starts at the first rising clock after select falls
// - while select is high, clock and data are ignored, state returns to idle
// - frame is 7 address bits, read/write bit, then 16 data bits
// - address and data travel most significant bit first
// - select rising early writes only the data bits clocked in
// - more than sixteen write bits: the last sixteen are written
// - a read shifts out up to sixteen register bits, msb first
module three_wire_register_port (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe,
  output spi_port_pkg::reg_access_type wr_access,
  output logic wr_strobe,
  output logic [4:0] wr_count,
  output logic [6:0] rd_addr,
  output logic rd_strobe,
  input wire logic [15:0] rd_data
);

  logic sclk_s;
  logic cs_n_s;
  logic sel_s;
  logic sdio_s;
  logic sclk_d_r;
  logic [4:0] cnt_r;
  logic [7:0] head_r;
  logic [15:0] shift_r;
  logic [15:0] rd_shift_r;
  spi_port_pkg::frame_state_type state_r;

  pin_sync u_sync_sclk (.clk(clk), .resetn(resetn), .pin(sclk), .synced(sclk_s));
  // select is synchronised inverted so that reset leaves the port deselected, not selected
  pin_sync u_sync_cs (.clk(clk), .resetn(resetn), .pin(!cs_n), .synced(sel_s));
  pin_sync u_sync_sdio (.clk(clk), .resetn(resetn), .pin(sdio_in), .synced(sdio_s));

  wire rise = sclk_s && !sclk_d_r;
  wire fall = !sclk_s && sclk_d_r;
  assign cs_n_s = !sel_s;
  wire active = !cs_n_s;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      sclk_d_r <= 1'b0;
    else
      sclk_d_r <= sclk_s;
  end

  // --------------------------------------------------------------------------
  // frame sequencing
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= spi_port_pkg::st_idle;
      cnt_r <= 5'h00;
      head_r <= 8'h00;
      shift_r <= spi_port_pkg::data_reset;
    end
    else if (!active)
    begin
      state_r <= spi_port_pkg::st_idle;
      cnt_r <= 5'h00;
    end
    else if (rise)
    begin
      unique case (state_r)
        spi_port_pkg::st_idle:
        begin
          head_r <= {7'h00, sdio_s};
          cnt_r <= 5'h01;
          state_r <= spi_port_pkg::st_head;
        end
        spi_port_pkg::st_head:
        begin
          head_r <= {head_r[6:0], sdio_s};
          if (cnt_r == spi_port_pkg::head_last)
          begin
            cnt_r <= 5'h00;
            if (sdio_s == spi_port_pkg::read_flag)
              state_r <= spi_port_pkg::st_read;
            else
              state_r <= spi_port_pkg::st_write;
          end
          else
            cnt_r <= cnt_r + 5'h01;
        end
        spi_port_pkg::st_write:
        begin
          shift_r <= {shift_r[14:0], sdio_s};
          if (cnt_r != spi_port_pkg::data_count_max)
            cnt_r <= cnt_r + 5'h01;
        end
        spi_port_pkg::st_read:
        begin
          if (cnt_r != spi_port_pkg::data_count_max)
            cnt_r <= cnt_r + 5'h01;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // register side
  // --------------------------------------------------------------------------
  // partial writes hand over the count so the register keeps its other bits
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_strobe <= 1'b0;
      wr_access <= '0;
      wr_count <= 5'h00;
    end
    else
    begin
      wr_strobe <= 1'b0;
      if (!active && state_r == spi_port_pkg::st_write && cnt_r != 5'h00)
      begin
        wr_strobe <= 1'b1;
        wr_access.addr <= head_r[7:1];
        wr_access.data <= shift_r;
        wr_count <= cnt_r;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_strobe <= 1'b0;
      rd_addr <= 7'h00;
    end
    else
    begin
      rd_strobe <= active && rise && state_r == spi_port_pkg::st_head
                   && cnt_r == spi_port_pkg::head_last && sdio_s == spi_port_pkg::read_flag;
      if (active && rise && state_r == spi_port_pkg::st_head && cnt_r == 5'h06)
        rd_addr <= {head_r[5:0], sdio_s};
    end
  end

  // --------------------------------------------------------------------------
  // data line drive
  // --------------------------------------------------------------------------
  // bits change on the falling edge so the host samples them on the rising one
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sdio_oe <= 1'b0;
      sdio_out <= 1'b0;
      rd_shift_r <= spi_port_pkg::data_reset;
    end
    else if (!active)
    begin
      sdio_oe <= 1'b0;
      sdio_out <= 1'b0;
    end
    else if (state_r == spi_port_pkg::st_read && fall)
    begin
      sdio_oe <= 1'b1;
      if (cnt_r == 5'h00)
      begin
        sdio_out <= rd_data[15];
        rd_shift_r <= {rd_data[14:0], 1'b0};
      end
      else
      begin
        sdio_out <= rd_shift_r[15]; // zeros past sixteen bits
        rd_shift_r <= {rd_shift_r[14:0], 1'b0};
      end
    end
  end

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  sequence s_deselect;
    $rose(cs_n_s);
  endsequence

  property p_release;
    @(posedge clk) disable iff (!resetn) s_deselect |=> !sdio_oe;
  endproperty
  a_release: assert property (p_release) else $error("data line still driven after deselect");

  property p_idle_quiet;
    @(posedge clk) disable iff (!resetn) !active |=> state_r == spi_port_pkg::st_idle && !rd_strobe;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("activity while deselected");

  property p_start;
    @(posedge clk) disable iff (!resetn)
      active && rise && state_r == spi_port_pkg::st_idle |=> state_r == spi_port_pkg::st_head && cnt_r == 5'h01;
  endproperty
  a_start: assert property (p_start) else $error("frame did not start");

  property p_write_commit;
    @(posedge clk) disable iff (!resetn)
      !active && state_r == spi_port_pkg::st_write && cnt_r != 5'h00 |=> wr_strobe && wr_count == $past(cnt_r);
  endproperty
  a_write_commit: assert property (p_write_commit) else $error("write not committed");

  property p_count_cap;
    @(posedge clk) disable iff (!resetn) cnt_r <= spi_port_pkg::data_count_max;
  endproperty
  a_count_cap: assert property (p_count_cap) else $error("bit count overran");

  property p_no_drive_write;
    @(posedge clk) disable iff (!resetn) state_r != spi_port_pkg::st_read |=> !sdio_oe;
  endproperty
  a_no_drive_write: assert property (p_no_drive_write) else $error("driven outside read");

  property p_head_len;
    @(posedge clk) disable iff (!resetn)
      (state_r == spi_port_pkg::st_write || state_r == spi_port_pkg::st_read) && $past(state_r) == spi_port_pkg::st_head
      |-> $past(cnt_r) == spi_port_pkg::head_last && $past(rise);
  endproperty
  a_head_len: assert property (p_head_len) else $error("header count wrong");

  property p_sample_shift;
    @(posedge clk) disable iff (!resetn)
      active && rise && state_r == spi_port_pkg::st_write |=> shift_r[0] == $past(sdio_s);
  endproperty
  a_sample_shift: assert property (p_sample_shift) else $error("bit not sampled");

endmodule

`default_nettype wire

// ### testbench/host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----
// serial host
// ----
module host_model (
  input wire logic clk,
  input wire logic line,
  output var logic sclk,
  output var logic cs_n,
  output var logic sdio
);
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdio = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // on writes, data bits come from the low n bits of w, msb first; on reads the host toggles sdio
  task automatic frame(input logic [7:0] h, input logic [31:0] w, input int n,
    output logic [15:0] q);
    q = 16'h0000;
    cs_n = 1'b0;
    tick(4);
    for (int i = 0; i < 8 + n; i++)
    begin
      sclk = 1'b0;
      if (i < 8)
        sdio = h[7 - i];
      else if (!h[0])
        sdio = w[n + 7 - i];
      else
        sdio = ~sdio;
      tick(4);
      sclk = 1'b1;
      tick(4);
      // bits past the sixteenth are not trusted
      if (i >= 8 && i < 24)
        q[23 - i] = line;
    end
    tick(4);
    cs_n = 1'b1;
    tick(12);
  endtask

  task automatic noise();
    repeat (16)
    begin
      sclk = ~sclk;
      sdio = ~sdio;
      tick(4);
    end
  endtask
endmodule

`default_nettype wire

// ### testbench/three_wire_register_port_bench.sv
`timescale 1ns/1ps
`default_nettype none

// ----
// bench
// ----
module three_wire_register_port_bench;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic sclk, cs_n, sdio, line, sdio_out, sdio_oe, wr_strobe, rd_strobe;
  logic [4:0] wr_count, got_n;
  logic [6:0] rd_addr, exp_addr;
  logic [15:0] rd_data = 16'h0000;
  spi_port_pkg::reg_access_type wr_access, got;
  int n_wr = 0;
  int n_rd = 0;
  int n_fail = 0;
  int compares = 0;
  int seed = 51174;

  // the block's drive wins; otherwise the host's level
  assign line = sdio_oe ? sdio_out : sdio;

  initial
  begin
    forever #10 clk = ~clk;
  end

  host_model i_host_model (.clk(clk), .line(line), .sclk(sclk), .cs_n(cs_n), .sdio(sdio));

  three_wire_register_port i_three_wire_register_port (.clk(clk), .resetn(resetn),
    .sclk(sclk), .cs_n(cs_n), .sdio_in(line), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .wr_access(wr_access), .wr_strobe(wr_strobe), .wr_count(wr_count),
    .rd_addr(rd_addr), .rd_strobe(rd_strobe), .rd_data(rd_data));

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  always @(posedge clk)
  begin
    if (wr_strobe === 1'b1)
    begin
      got <= wr_access;
      got_n <= wr_count;
      n_wr <= n_wr + 1;
    end
    if (rd_strobe === 1'b1)
    begin
      n_rd <= n_rd + 1;
      check("rd_addr", exp_addr, rd_addr);
    end
  end

  task automatic do_write(input logic [6:0] a, input logic [31:0] w, input int n);
    int k;
    logic [15:0] q;
    logic [15:0] m;
    k = n_wr;
    i_host_model.frame({a, 1'b0}, w, n, q);
    m = (n >= 16) ? 16'hffff : 16'((1 << n) - 1);
    if (n == 0)
      check("no_strobe", k, n_wr);
    else
    begin
      check("wr_seen", k + 1, n_wr);
      check("wr_addr", a, got.addr);
      check("wr_data", w[15:0] & m, got.data & m);
      check("wr_count", (n > 16) ? 16 : n, got_n);
    end
  endtask

  task automatic do_read(input logic [6:0] a, input int n);
    int k;
    logic [15:0] q;
    k = n_rd;
    exp_addr = a;
    // read data is drawn afresh, never taken from earlier writes
    rd_data = 16'($random(seed));
    i_host_model.frame({a, 1'b1}, 32'h0000_0000, n, q);
    check("rd_seen", k + 1, n_rd);
    check("rd_bits", rd_data, q);
    check("sdio_oe", 1'b0, sdio_oe);
  endtask

  task automatic stop_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    repeat (8) @(negedge clk);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    do_write(7'h7f, 32'h0000_a5c3, 16);
    do_write(7'h00, 32'h000f_1234, 20);
    do_write(7'h15, 32'h0000_0001, 1);
    do_write(7'h2a, 32'h0000_0000, 0);
    i_host_model.noise();
    check("idle_wr", 3, n_wr);
    check("idle_rd", 0, n_rd);
    do_read(7'h40, 18);
    for (int i = 0; i < 12; i++)
    begin
      do_write(7'($random(seed)), $random(seed), 1 + {$random(seed)} % 20);
      do_read(7'($random(seed)), 16 + {$random(seed)} % 3);
    end
    stop_test();
  end
endmodule

`default_nettype wire
